// [core/osc_control.sv]
`timescale 1ns/1ps
// Functional notes
// - PLL output divided by field 29-27: 1,2,4,8,16,32,64,256.
// - Fast RC divided by field 26-24; default code 001, divide by 2.
// - Bit 22 reads one when secondary oscillator runs and is stable.
// - Bit 21 shows the peripheral divisor may be written; writes to bits 20-19 are dropped while it reads zero.
// - Peripheral clock is system clock divided 1,2,4,8 by bits 20-19.
// - PLL multiplier by bits 18-16: 15 to 21, then 24.
// - Bits 14-12 report the active clock source, read only.
// - Bits 10-8 hold the requested new source, same encoding.
// - Requested source reloads from configuration bits on reset.
// - Bit 7 freezes selections only when monitor config is 1x.
// - Bit 6 reads one when USB PLL locked.
// - Bit 5 reads one when system PLL locked.
// - Bit 4 one makes wait enter sleep, zero makes it idle.
// - Writes are ignored unless the unlock sequence came first.
// - Bits 31-30, 23, 15 and 11 read zero, writes ignored.
// - Configuration-derived fields load from configuration bits on reset.
// - Writing bit 0 starts a switch; hardware clears it when done.
// - Bit 3 is set when the fail-safe monitor sees a failure.
// - Bit 2 selects fast RC as USB clock, else primary or PLL.
// - Bit 1 enables the secondary oscillator.
module osc_control
  import osc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [2:0] initial_source_config,
  input wire logic [1:0] switch_monitor_config,
  input wire logic [2:0] cfg_post_divider,
  input wire logic [1:0] cfg_periph_divisor,
  input wire logic [2:0] cfg_multiplier,
  input wire logic cfg_usb_from_fast_rc,
  input wire logic sosc_stable_pin,
  input wire logic usb_pll_lock_pin,
  input wire logic sys_pll_lock_pin,
  input wire logic clock_fail_pin,
  input wire logic wait_exec,
  output logic [2:0] pll_post_divider,
  output logic [8:0] post_divide_ratio,
  output logic [2:0] fast_rc_divider,
  output logic [8:0] fast_rc_ratio,
  output logic [2:0] pll_multiplier,
  output logic [4:0] multiply_factor,
  output logic [2:0] current_source_sel,
  output logic periph_bus_tick,
  output logic secondary_osc_enable,
  output logic usb_from_fast_rc,
  output logic sleep_req,
  output logic idle_req
);

  logic [2:0] post_div_reg;
  logic [2:0] frc_div_reg;
  logic [1:0] pb_div_reg;
  logic [2:0] mult_reg;
  logic [2:0] cur_src_reg;
  logic [2:0] req_src_reg;
  logic sel_lock_reg;
  logic sleep_en_reg;
  logic fail_reg;
  logic usb_frc_reg;
  logic sosc_en_reg;
  logic switch_reg;
  logic [3:0] switch_cnt_reg;
  logic load_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  osc_unlock_t unlock_reg;
  osc_unlock_t unlock_next;
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic periph_divisor_writable;
  logic bus_req;
  logic wr_ctrl;
  logic wr_key;
  logic frozen;
  logic switch_done;
  logic [31:0] ctrl_word;
  logic [31:0] wmask;
  logic [31:0] wval;

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}},
                  {8{wb_sel_i[0]}}};
  assign wval = (ctrl_word & ~wmask) | (wb_dat_i & wmask);
  assign wr_key = bus_req && wb_we_i && (wb_adr_i == OSC_ADDR_UNLOCK);
  assign wr_ctrl = bus_req && wb_we_i && (wb_adr_i == OSC_ADDR_CTRL)
                   && (unlock_reg == OSC_OPEN);
  assign frozen = switch_monitor_config[1] && sel_lock_reg;
  assign switch_done = switch_reg && (switch_cnt_reg == OSC_SWITCH_CYCLES);

  // Pins from the analog side pass two flops before use.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end
    else
    begin
      sync1_reg <= {clock_fail_pin, sys_pll_lock_pin, usb_pll_lock_pin,
                    sosc_stable_pin};
      sync2_reg <= sync1_reg;
    end
  end

  // Two key words in consecutive writes open the register for one write.
  always_comb
  begin
    unlock_next = unlock_reg;
    if (wr_key)
    begin
      if (wb_dat_i == OSC_KEY_FIRST)
        unlock_next = OSC_KEY_ONE;
      else if (wb_dat_i == OSC_KEY_SECOND && unlock_reg == OSC_KEY_ONE)
        unlock_next = OSC_OPEN;
      else
        unlock_next = OSC_IDLE;
    end
    else if (bus_req && wb_we_i)
    begin
      unlock_next = OSC_IDLE;
    end
    else
    begin
      case (unlock_reg)
        OSC_IDLE: unlock_next = OSC_IDLE;
        OSC_KEY_ONE: unlock_next = OSC_KEY_ONE;
        OSC_OPEN: unlock_next = OSC_OPEN;
        default: unlock_next = OSC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      unlock_reg <= OSC_IDLE;
    else
      unlock_reg <= unlock_next;
  end

  // Configuration words are caught on the first clock after reset release.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      load_reg <= 1'b1;
    else
      load_reg <= 1'b0;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      post_div_reg <= 3'h0;
      pb_div_reg <= 2'h3;
      mult_reg <= 3'h0;
      req_src_reg <= 3'h0;
      usb_frc_reg <= 1'b0;
    end
    else if (load_reg)
    begin
      post_div_reg <= cfg_post_divider;
      pb_div_reg <= cfg_periph_divisor;
      mult_reg <= cfg_multiplier;
      req_src_reg <= initial_source_config;
      usb_frc_reg <= cfg_usb_from_fast_rc;
    end
    else if (wr_ctrl)
    begin
      if (!frozen)
      begin
        post_div_reg <= wval[OSC_POS_POST_DIV +: 3];
        mult_reg <= wval[OSC_POS_PLL_MULT +: 3];
        req_src_reg <= wval[OSC_POS_REQ_SRC +: 3];
      end
      if (periph_divisor_writable)
        pb_div_reg <= wval[OSC_POS_PB_DIV +: 2];
      usb_frc_reg <= wval[OSC_POS_USB_FRC];
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      frc_div_reg <= OSC_RST_FRC_DIV;
      sel_lock_reg <= 1'b0;
      sleep_en_reg <= 1'b0;
      sosc_en_reg <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      frc_div_reg <= wval[OSC_POS_FRC_DIV +: 3];
      sel_lock_reg <= wval[OSC_POS_SEL_LOCK] | sel_lock_reg;
      sleep_en_reg <= wval[OSC_POS_SLEEP];
      sosc_en_reg <= wval[OSC_POS_SOSC_EN];
    end
  end

  // Failure flag: a detected failure wins over a software clear.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      fail_reg <= 1'b0;
    else if (sync2_reg[3])
      fail_reg <= 1'b1;
    else if (wr_ctrl)
      fail_reg <= wval[OSC_POS_FAIL];
  end

  // Switch sequence: a fixed settle time, then the source changes over.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      switch_reg <= 1'b0;
      switch_cnt_reg <= 4'h0;
      cur_src_reg <= OSC_RST_CUR_SRC;
    end
    else if (load_reg)
    begin
      cur_src_reg <= initial_source_config;
    end
    else if (switch_done)
    begin
      switch_reg <= 1'b0;
      switch_cnt_reg <= 4'h0;
      cur_src_reg <= req_src_reg;
    end
    else if (switch_reg)
    begin
      switch_cnt_reg <= switch_cnt_reg + 4'h1;
    end
    else if (wr_ctrl && !frozen && wval[OSC_POS_SWITCH])
    begin
      switch_reg <= 1'b1;
    end
  end

  always_comb
  begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[OSC_POS_POST_DIV +: 3] = post_div_reg;
    ctrl_word[OSC_POS_FRC_DIV +: 3] = frc_div_reg;
    ctrl_word[OSC_POS_SOSC_RDY] = sync2_reg[0] && sosc_en_reg;
    ctrl_word[OSC_POS_PB_WRITABLE] = periph_divisor_writable;
    ctrl_word[OSC_POS_PB_DIV +: 2] = pb_div_reg;
    ctrl_word[OSC_POS_PLL_MULT +: 3] = mult_reg;
    ctrl_word[OSC_POS_CUR_SRC +: 3] = cur_src_reg;
    ctrl_word[OSC_POS_REQ_SRC +: 3] = req_src_reg;
    ctrl_word[OSC_POS_SEL_LOCK] = sel_lock_reg;
    ctrl_word[OSC_POS_USB_LOCK] = sync2_reg[1];
    ctrl_word[OSC_POS_SYS_LOCK] = sync2_reg[2];
    ctrl_word[OSC_POS_SLEEP] = sleep_en_reg;
    ctrl_word[OSC_POS_FAIL] = fail_reg;
    ctrl_word[OSC_POS_USB_FRC] = usb_frc_reg;
    ctrl_word[OSC_POS_SOSC_EN] = sosc_en_reg;
    ctrl_word[OSC_POS_SWITCH] = switch_reg;
  end

  // One-wait-state slave; unmapped addresses are acknowledged and read zero.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= bus_req;
      if (bus_req && !wb_we_i)
        rdata_reg <= (wb_adr_i == OSC_ADDR_CTRL) ? ctrl_word : 32'h0000_0000;
    end
  end

  // Wait instruction outputs a one-cycle sleep or idle request.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sleep_req <= 1'b0;
      idle_req <= 1'b0;
    end
    else
    begin
      sleep_req <= wait_exec && sleep_en_reg;
      idle_req <= wait_exec && !sleep_en_reg;
    end
  end

  osc_pb_divider u_pb_div
  (
    .clock(clock),
    .rst_b(rst_b),
    .divisor(pb_div_reg),
    .tick(periph_bus_tick),
    .writable(periph_divisor_writable)
  );

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign pll_post_divider = post_div_reg;
  assign post_divide_ratio = osc_div_ratio(post_div_reg);
  assign fast_rc_divider = frc_div_reg;
  assign fast_rc_ratio = osc_div_ratio(frc_div_reg);
  assign pll_multiplier = mult_reg;
  assign multiply_factor = (mult_reg == 3'h7) ? 5'h18
                           : 5'(5'h0f + {2'h0, mult_reg});
  assign current_source_sel = cur_src_reg;
  assign secondary_osc_enable = sosc_en_reg;
  assign usb_from_fast_rc = usb_frc_reg;

endmodule : osc_control

// [core/osc_pkg.sv]
package osc_pkg;

  localparam logic [3:0] OSC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] OSC_ADDR_UNLOCK = 4'h4;
  localparam logic [31:0] OSC_KEY_FIRST = 32'haa99_6655;
  localparam logic [31:0] OSC_KEY_SECOND = 32'h5566_99aa;

  localparam int OSC_POS_POST_DIV = 27;
  localparam int OSC_POS_FRC_DIV = 24;
  localparam int OSC_POS_SOSC_RDY = 22;
  localparam int OSC_POS_PB_WRITABLE = 21;
  localparam int OSC_POS_PB_DIV = 19;
  localparam int OSC_POS_PLL_MULT = 16;
  localparam int OSC_POS_CUR_SRC = 12;
  localparam int OSC_POS_REQ_SRC = 8;
  localparam int OSC_POS_SEL_LOCK = 7;
  localparam int OSC_POS_USB_LOCK = 6;
  localparam int OSC_POS_SYS_LOCK = 5;
  localparam int OSC_POS_SLEEP = 4;
  localparam int OSC_POS_FAIL = 3;
  localparam int OSC_POS_USB_FRC = 2;
  localparam int OSC_POS_SOSC_EN = 1;
  localparam int OSC_POS_SWITCH = 0;

  localparam logic [2:0] OSC_RST_FRC_DIV = 3'h1;
  localparam logic [2:0] OSC_RST_CUR_SRC = 3'h0;
  localparam logic [3:0] OSC_SWITCH_CYCLES = 4'h8;

  typedef enum logic [1:0]
  {
    OSC_IDLE = 2'h0,
    OSC_KEY_ONE = 2'h1,
    OSC_OPEN = 2'h3
  } osc_unlock_t;

  function automatic logic [8:0] osc_div_ratio(input logic [2:0] code);
    osc_div_ratio = (code == 3'h7) ? 9'h100 : (9'h001 << code);
  endfunction : osc_div_ratio

endpackage : osc_pkg

// [core/osc_pb_divider.sv]
`timescale 1ns/1ps
module osc_pb_divider
  import osc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [1:0] divisor,
  output logic tick,
  output logic writable
);

  logic [2:0] count_reg;
  logic [1:0] active_reg;
  logic [2:0] limit;

  assign limit = 3'((9'(osc_div_ratio({1'b0, active_reg}))) - 9'h001);

  // A new divisor is only taken at a period boundary, so no short pulse.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_reg <= 3'h0;
      active_reg <= 2'h3;
    end
    else if (count_reg >= limit)
    begin
      count_reg <= 3'h0;
      active_reg <= divisor;
    end
    else
    begin
      count_reg <= count_reg + 3'h1;
    end
  end

  assign tick = (count_reg >= limit);
  assign writable = (divisor == active_reg);

endmodule : osc_pb_divider

// [sim/osc_control_sva.sv]
`timescale 1ns/1ps
module osc_control_sva
  import osc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wait_exec,
  input wire logic sleep_req,
  input wire logic idle_req,
  input wire logic [2:0] pll_post_divider,
  input wire logic [8:0] post_divide_ratio,
  input wire logic [2:0] fast_rc_divider,
  input wire logic [8:0] fast_rc_ratio,
  input wire logic [2:0] pll_multiplier,
  input wire logic [4:0] multiply_factor
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  ack_answer_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  post_ratio_a: assert property (post_divide_ratio ==
    ((pll_post_divider == 3'h7) ? 9'h100 : 9'h001 << pll_post_divider))
    else $error("bad post ratio");
  frc_ratio_a: assert property (fast_rc_ratio ==
    ((fast_rc_divider == 3'h7) ? 9'h100 : 9'h001 << fast_rc_divider))
    else $error("bad rc ratio");
  mult_factor_a: assert property (multiply_factor ==
    ((pll_multiplier == 3'h7) ? 5'h18 : 5'h0f + pll_multiplier))
    else $error("bad multiplier");
  wait_mode_a: assert property (
    wait_exec |=> sleep_req != idle_req) else $error("no wait mode");
  wait_cause_a: assert property (
    sleep_req || idle_req |-> $past(wait_exec)) else $error("stray mode");
endmodule : osc_control_sva

bind osc_control osc_control_sva osc_control_sva_inst (.clock, .rst_b,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wait_exec, .sleep_req, .idle_req,
  .pll_post_divider, .post_divide_ratio, .fast_rc_divider, .fast_rc_ratio,
  .pll_multiplier, .multiply_factor);

// [sim/oscillator_source_select_control_bench.sv]
`timescale 1ns/1ps
module oscillator_source_select_control_bench
  import osc_pkg::*;
;
  logic clock = 1'b0, rst_b = 1'b0, wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [2:0] initial_source_config = 3'h2, cfg_post_divider = 3'h3;
  logic [2:0] cfg_multiplier = 3'h5, pll_post_divider, current_source_sel;
  logic [1:0] switch_monitor_config = 2'h0, cfg_periph_divisor = 2'h3;
  logic cfg_usb_from_fast_rc = 1'b1, sosc_stable_pin = 1'b1;
  logic usb_pll_lock_pin = 1'b0, sys_pll_lock_pin = 1'b0;
  logic clock_fail_pin = 1'b0, wait_exec = 1'b0;
  logic periph_bus_tick, sleep_req, idle_req;
  logic secondary_osc_enable, usb_from_fast_rc;
  int n_mismatch = 0, total_checks = 0, n_tick = 0, i;

  osc_control osc_control_inst (.clock, .rst_b, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .initial_source_config, .switch_monitor_config, .cfg_post_divider,
    .cfg_periph_divisor, .cfg_multiplier, .cfg_usb_from_fast_rc,
    .sosc_stable_pin, .usb_pll_lock_pin, .sys_pll_lock_pin,
    .clock_fail_pin, .wait_exec, .pll_post_divider, .post_divide_ratio(),
    .fast_rc_divider(), .fast_rc_ratio(), .pll_multiplier(),
    .multiply_factor(), .current_source_sel, .periph_bus_tick,
    .secondary_osc_enable, .usb_from_fast_rc, .sleep_req, .idle_req);

  initial
  begin
    forever #50 clock = ~clock;
  end

  // Ticks are counted on the falling edge, where the divider has settled.
  always @(negedge clock)
    if (periph_bus_tick === 1'b1)
      n_tick++;

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Holds the request until ack is seen at an edge, then releases it.
  task automatic wb(input logic we, input logic [3:0] a,
    input logic [31:0] d);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic rdc();
    wb(1'b0, OSC_ADDR_CTRL, 32'h0);
  endtask : rdc

  task automatic wctl(input logic [31:0] d);
    wb(1'b1, OSC_ADDR_UNLOCK, OSC_KEY_FIRST);
    wb(1'b1, OSC_ADDR_UNLOCK, OSC_KEY_SECOND);
    wb(1'b1, OSC_ADDR_CTRL, d);
  endtask : wctl

  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    repeat (2) @(posedge clock);
  endtask : do_reset

  task automatic pulse_wait(input logic [1:0] exp);
    @(posedge clock);
    wait_exec <= 1'b1;
    @(posedge clock);
    wait_exec <= 1'b0;
    #1;
    check({sleep_req, idle_req}, exp);
    @(posedge clock);
  endtask : pulse_wait

  initial
  begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    final_report();
  end

  // Bit 21 follows the divider's period boundary, so it is masked here.
  initial
  begin
    do_reset();
    i = n_tick;
    repeat (80) @(posedge clock);
    check(n_tick - i, 10);
    rdc();
    check(rd & 32'hffdf_ffff, 32'h191d_2204);
    check(rd[21], 1'b1);
    wb(1'b0, 4'h8, 32'h0);
    check(rd, 32'h0);
    $display("test reset done");
    wb(1'b1, OSC_ADDR_CTRL, 32'hffff_fff7);
    wb(1'b1, OSC_ADDR_UNLOCK, OSC_KEY_FIRST);
    wb(1'b1, OSC_ADDR_UNLOCK, OSC_KEY_SECOND);
    wb(1'b1, 4'h8, 32'h0);
    wb(1'b1, OSC_ADDR_CTRL, 32'hffff_fff7);
    rdc();
    check(rd & 32'hffdf_ffff, 32'h191d_2204);
    $display("test locked write done");
    usb_pll_lock_pin <= 1'b1;
    sys_pll_lock_pin <= 1'b1;
    wctl(32'hffff_fff7);
    rdc();
    check(rd & 32'hffdf_ffff, 32'h3f5f_27f7);
    check(pll_post_divider, 3'h7);
    check(secondary_osc_enable, 1'b1);
    check(usb_from_fast_rc, 1'b1);
    for (i = 0; i < 20 && rd[0] !== 1'b0; i++)
      rdc();
    check(rd[0], 1'b0);
    check(rd[14:12], 3'h7);
    check(current_source_sel, 3'h7);
    pulse_wait(2'b10);
    clock_fail_pin <= 1'b1;
    repeat (4) @(posedge clock);
    rdc();
    check(rd[3], 1'b1);
    $display("test switch done");
    switch_monitor_config <= 2'h2;
    clock_fail_pin <= 1'b0;
    do_reset();
    wctl(32'h191d_2284);
    wctl(32'h011d_2505);
    rdc();
    check(rd & 32'hffdf_ffff, 32'h191d_22e4);
    pulse_wait(2'b01);
    wb_sel_i <= 4'h1;
    wctl(32'hffff_ff10);
    rdc();
    check(rd & 32'hffdf_ffff, 32'h191d_22f0);
    check(usb_from_fast_rc, 1'b0);
    pulse_wait(2'b10);
    $display("test freeze done");
    final_report();
  end
endmodule : oscillator_source_select_control_bench
